// ### hdl/reserved_bank.sv
`timescale 1ns/1ps

module reserved_bank #(
   parameter logic [63:0] KIND_MAP  = resv_pkg::RSV_KIND,
   parameter logic [31:0] LEVEL_MAP = resv_pkg::RSV_LEVEL,
   parameter logic [31:0] RST_MAP   = resv_pkg::HAS_RESET,
   parameter logic [31:0] RST_VALS  = resv_pkg::RESET_VALUE
) (
   input  wire logic                        core_clk,
   input  wire logic                        rst,
   input  wire logic                        dir_we,
   input  wire logic                        ind_we,
   input  wire logic [resv_pkg::DATA_W-1:0] wr_data,
   output logic      [resv_pkg::DATA_W-1:0] rd_data,
   output logic      [resv_pkg::DATA_W-1:0] func_bits,
   input  wire logic                        enc_valid,
   input  wire resv_pkg::enc_class_t        enc_class,
   input  wire logic [1:0]                  cur_level,
   output logic                             undef_exc,
   output logic [1:0]                       exc_level,
   output logic                             unpred_flag
);
   import resv_pkg::*;

   logic [DATA_W-1:0] cell_rd;
   logic [DATA_W-1:0] func_mask;

   // ------------------------------------------------------------
   // Per-bit cells, each kind chosen per bit by the kind map
   // ------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < DATA_W; gi++) begin : g_bit
         localparam logic [1:0] K = KIND_MAP[2*gi +: 2];
         reserved_cell #(
            .KIND    (K),
            .LEVEL   (LEVEL_MAP[gi]),
            .HAS_RST (RST_MAP[gi]),
            .RST_VAL (RST_VALS[gi])
         ) u_cell (
            .core_clk (core_clk),
            .rst      (rst),
            .dir_we   (dir_we),
            .ind_we   (ind_we),
            .wr_bit   (wr_data[gi]),
            .rd_bit   (cell_rd[gi])
         );
         assign func_mask[gi] = (K == KIND_FUNC);
      end
   endgenerate

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   // Reserved positions are masked in func_bits so they cannot steer logic; rd_data shows them
   assign rd_data   = cell_rd;
   assign func_bits = cell_rd & func_mask;

   // ------------------------------------------------------------
   // Encoding check
   // ------------------------------------------------------------
   // Unpredictable classes are flagged; only 64-bit ones trap.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         undef_exc   <= 1'b0;
         exc_level   <= LOWEST_LEVEL;
         unpred_flag <= 1'b0;
      end else begin
         undef_exc   <= enc_valid && enc_class == ENC_RSV_64;
         unpred_flag <= enc_valid && (enc_class == ENC_RSV_INSN ||
                                      enc_class == ENC_RSV_32);
         if (enc_valid && enc_class == ENC_RSV_64) begin
            exc_level <= (cur_level == LOWEST_LEVEL) ?
                         DEFAULT_TGT_LEVEL : cur_level;
         end
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   // One set of checks per bit, picked by that bit's kind
   genvar ai;
   generate
      for (ai = 0; ai < DATA_W; ai++) begin : g_chk
         localparam logic [1:0] KA = KIND_MAP[2*ai +: 2];
         // Constant bits: nothing a write does may ever show
         if (KA == KIND_HARD || KA == KIND_RO) begin : g_fix
            fixed_read_a: assert property (
               @(posedge core_clk) disable iff (rst)
               rd_data[ai] == LEVEL_MAP[ai])
               else $error("fixed reserved bit changed");
            fixed_hidden_a: assert property (
               @(posedge core_clk) disable iff (rst)
               func_bits[ai] == 1'b0)
               else $error("fixed reserved bit leaks into logic");
         end else if (KA == KIND_STORE) begin : g_st
            // Indirect write wins when both strobes meet
            both_strobes_a: assert property (
               @(posedge core_clk) disable iff (rst)
               dir_we && ind_we |=> rd_data[ai] == LEVEL_MAP[ai])
               else $error("indirect write lost to direct write");
            if (RST_MAP[ai]) begin : g_rv
               reset_value_a: assert property (
                  @(posedge core_clk) disable iff (rst)
                  $fell(rst) |-> rd_data[ai] == RST_VALS[ai])
                  else $error("stored bit missed its reset value");
            end
            ind_force_a: assert property (
               @(posedge core_clk) disable iff (rst)
               ind_we |=> rd_data[ai] == LEVEL_MAP[ai])
               else $error("indirect write did not force level");
            dir_store_a: assert property (
               @(posedge core_clk) disable iff (rst)
               dir_we && !ind_we |=> rd_data[ai] == $past(wr_data[ai]))
               else $error("direct write not stored");
            hold_value_a: assert property (
               @(posedge core_clk) disable iff (rst)
               !dir_we && !ind_we |=> $stable(rd_data[ai]))
               else $error("stored bit changed without write");
            masked_func_a: assert property (
               @(posedge core_clk) disable iff (rst)
               func_bits[ai] == 1'b0)
               else $error("reserved bit leaks into logic");
         end else begin : g_fn
            // Functional bits store every direct write, ignore the rest
            func_pass_a: assert property (
               @(posedge core_clk) disable iff (rst)
               func_bits[ai] == rd_data[ai])
               else $error("functional bit hidden from logic");
            func_store_a: assert property (
               @(posedge core_clk) disable iff (rst)
               dir_we |=> rd_data[ai] == $past(wr_data[ai]))
               else $error("functional bit lost a direct write");
            func_keep_a: assert property (
               @(posedge core_clk) disable iff (rst)
               !dir_we |=> $stable(rd_data[ai]))
               else $error("functional bit changed without write");
         end
      end
   endgenerate

   // ------------------------------------------------------------
   // Encoding checks
   // ------------------------------------------------------------
   // Only the 64-bit class may trap; the others stay a flag so that
   // a later core can choose to trap them without a redesign; ENC_VALID is neither trapped nor flagged.
   undef_trap_a: assert property (
      @(posedge core_clk) disable iff (rst)
      enc_valid && enc_class == ENC_RSV_64 |=> undef_exc)
      else $error("reserved 64-bit encoding did not trap");

   no_trap_a: assert property (
      @(posedge core_clk) disable iff (rst)
      !(enc_valid && enc_class == ENC_RSV_64) |=> !undef_exc)
      else $error("spurious undefined exception");

   exc_target_a: assert property (
      @(posedge core_clk) disable iff (rst)
      enc_valid && enc_class == ENC_RSV_64 && cur_level == LOWEST_LEVEL
      |=> exc_level == DEFAULT_TGT_LEVEL)
      else $error("lowest level trap went to wrong level");

   exc_current_a: assert property (
      @(posedge core_clk) disable iff (rst)
      enc_valid && enc_class == ENC_RSV_64 && cur_level != LOWEST_LEVEL
      |=> exc_level == $past(cur_level))
      else $error("trap not taken at current level");

   unpred_set_a: assert property (
      @(posedge core_clk) disable iff (rst)
      enc_valid && (enc_class == ENC_RSV_INSN || enc_class == ENC_RSV_32)
      |=> unpred_flag)
      else $error("unpredictable encoding not flagged");

   unpred_clr_a: assert property (
      @(posedge core_clk) disable iff (rst)
      !(enc_valid && (enc_class == ENC_RSV_INSN ||
                      enc_class == ENC_RSV_32)) |=> !unpred_flag)
      else $error("spurious unpredictable flag");

   trap_excl_a: assert property (
      @(posedge core_clk) disable iff (rst)
      !(undef_exc && unpred_flag))
      else $error("encoding both trapped and flagged");

   // The target level is read after the trap, so it must not drift
   level_hold_a: assert property (
      @(posedge core_clk) disable iff (rst)
      !(enc_valid && enc_class == ENC_RSV_64) |=> $stable(exc_level))
      else $error("trap level moved without a trap");

   trap_level_a: assert property (
      @(posedge core_clk) disable iff (rst)
      undef_exc |-> exc_level != LOWEST_LEVEL)
      else $error("trap taken to the lowest level");

   // A stale trap left over a reset would be taken twice
   reset_idle_a: assert property (
      @(posedge core_clk) disable iff (rst)
      $fell(rst) |-> !undef_exc && !unpred_flag &&
                     exc_level == LOWEST_LEVEL)
      else $error("encoding outputs not idle after reset");

endmodule

// ### hdl/reserved_cell.sv
`timescale 1ns/1ps

// One bit of a register with its reserved-bit treatment.
module reserved_cell #(
   parameter logic [1:0] KIND      = 2'h0,
   parameter logic       LEVEL     = 1'b0,
   parameter logic       HAS_RST   = 1'b1,
   parameter logic       RST_VAL   = 1'b0
) (
   input  wire logic core_clk,
   input  wire logic rst,
   input  wire logic dir_we,
   input  wire logic ind_we,
   input  wire logic wr_bit,
   output logic      rd_bit
);
   import resv_pkg::*;

   logic stored_reg;
   logic stored_next;

   // ------------------------------------------------------------
   // Next value
   // ------------------------------------------------------------
   // Indirect write forces the reserved level except on functional bits; direct write stores.
   always_comb begin
      stored_next = stored_reg;
      if (ind_we && KIND != KIND_FUNC) begin
         stored_next = LEVEL;
      end else if (dir_we) begin
         stored_next = wr_bit;
      end
   end

   // ------------------------------------------------------------
   // Storage
   // ------------------------------------------------------------
   generate
      if (HAS_RST) begin : g_rst
         always_ff @(posedge core_clk or posedge rst) begin
            if (rst) begin
               stored_reg <= RST_VAL;
            end else begin
               stored_reg <= stored_next;
            end
         end
      end else begin : g_norst
         // No reset: value before first write is arbitrary
         always_ff @(posedge core_clk) begin
            stored_reg <= stored_next;
         end
      end
   endgenerate

   // ------------------------------------------------------------
   // Read view
   // ------------------------------------------------------------
   always_comb begin
      case (KIND)
         KIND_HARD: rd_bit = LEVEL;
         KIND_RO:   rd_bit = LEVEL;
         default:   rd_bit = stored_reg;
      endcase
   end

endmodule

// ### pkg/resv_pkg.sv
package resv_pkg;

   // ------------------------------------------------------------
   // Register geometry
   // ------------------------------------------------------------
   localparam int unsigned DATA_W = 32;
   localparam int unsigned ADDR_W = 4;

   // ------------------------------------------------------------
   // Per-bit reserved behaviour codes (two bits per field bit)
   // ------------------------------------------------------------
   localparam logic [1:0] KIND_FUNC  = 2'h0;
   localparam logic [1:0] KIND_HARD  = 2'h1;
   localparam logic [1:0] KIND_STORE = 2'h2;
   localparam logic [1:0] KIND_RO    = 2'h3;

   // ------------------------------------------------------------
   // Encoding classes and privilege levels
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      ENC_VALID    = 2'h0,
      ENC_RSV_INSN = 2'h1,
      ENC_RSV_32   = 2'h2,
      ENC_RSV_64   = 2'h3
   } enc_class_t;

   localparam logic [1:0] LOWEST_LEVEL      = 2'h0;
   localparam logic [1:0] DEFAULT_TGT_LEVEL = 2'h1;

   // ------------------------------------------------------------
   // Reset values and default layout
   // ------------------------------------------------------------
   localparam logic [31:0] RESET_VALUE  = 32'h0000_0000;
   localparam logic [31:0] HAS_RESET    = 32'hFFFF_FFFF;
   // Bits 31:28 reserved-one; 23:18 mix constant, stored and read-only
   localparam logic [31:0] RSV_LEVEL    = 32'hF0A8_0000;
   localparam logic [63:0] RSV_KIND     = 64'h9A00_65F0_0000_0000;

endpackage

// ### test/tb.sv
`timescale 1ns/1ps

`define CHK(got, exp) begin \
   checks_done++; \
   if ((got) !== (exp)) begin \
      n_mismatch++; \
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp); \
   end \
end

module tb;
   import resv_pkg::*;

   // ------------------------------------------------------------
   // Stimulus, observed outputs and bench model state
   // ------------------------------------------------------------
   logic                core_clk    = 1'b0;
   logic                rst         = 1'b1;
   logic                dir_we      = 1'b0;
   logic                ind_we      = 1'b0;
   logic                enc_valid   = 1'b0;
   logic [DATA_W-1:0]   wr_data     = '0;
   enc_class_t          enc_class   = ENC_VALID;
   logic [1:0]          cur_level   = 2'h0;
   logic [DATA_W-1:0]   rd_data;
   logic [DATA_W-1:0]   func_bits;
   logic                undef_exc;
   logic                unpred_flag;
   logic [1:0]          exc_level;
   logic [DATA_W-1:0]   mdl;
   logic [1:0]          lvl_exp;
   logic                undef_exp;
   logic                unpred_exp;
   int                  n_mismatch  = 0;
   int                  checks_done = 0;

   // Free-running 50 MHz clock
   always #10 core_clk = ~core_clk;

   reserved_bank dut (
      .core_clk    (core_clk),
      .rst         (rst),
      .dir_we      (dir_we),
      .ind_we      (ind_we),
      .wr_data     (wr_data),
      .rd_data     (rd_data),
      .func_bits   (func_bits),
      .enc_valid   (enc_valid),
      .enc_class   (enc_class),
      .cur_level   (cur_level),
      .undef_exc   (undef_exc),
      .exc_level   (exc_level),
      .unpred_flag (unpred_flag)
   );

   // ------------------------------------------------------------
   // Expectation functions, per bit from the package layout
   // ------------------------------------------------------------
   // Indirect write wins over a direct one on reserved stored bits
   function automatic logic [DATA_W-1:0] next_mdl(
      input logic [DATA_W-1:0] old, input logic [DATA_W-1:0] d,
      input logic dw, input logic iw);
      logic [DATA_W-1:0] r;
      logic [1:0]        k;
      r = old;
      for (int i = 0; i < DATA_W; i++) begin
         k = RSV_KIND[2*i +: 2];
         if (k == KIND_FUNC && dw) r[i] = d[i];
         if (k == KIND_STORE) r[i] = iw ? RSV_LEVEL[i] : (dw ? d[i] : old[i]);
      end
      return r;
   endfunction

   // Read side: constant kinds show their level, stored kinds the cell; logic side shows only functional bits
   function automatic logic [DATA_W-1:0] view(
      input logic [DATA_W-1:0] m, input logic logic_side);
      logic [DATA_W-1:0] r;
      logic [1:0]        k;
      for (int i = 0; i < DATA_W; i++) begin
         k = RSV_KIND[2*i +: 2];
         if (k == KIND_FUNC) r[i] = m[i];
         else if (logic_side) r[i] = 1'b0;
         else if (k == KIND_STORE) r[i] = m[i];
         else r[i] = RSV_LEVEL[i];
      end
      return r;
   endfunction

   // Software write policy: reserved positions carry their level
   function automatic logic [DATA_W-1:0] sw_policy(
      input logic [DATA_W-1:0] d);
      logic [DATA_W-1:0] r;
      r = d;
      for (int i = 0; i < DATA_W; i++) begin
         if (RSV_KIND[2*i +: 2] != KIND_FUNC) r[i] = RSV_LEVEL[i];
      end
      return r;
   endfunction

   // ------------------------------------------------------------
   // Closing report
   // ------------------------------------------------------------
   task automatic final_report();
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // ------------------------------------------------------------
   // Main sequence: directed corners first, then random traffic
   // ------------------------------------------------------------
   // Model follows what the edge just sampled, then compares
   initial begin
      void'($urandom(32'h125D));
      repeat (4) @(posedge core_clk);
      #1 rst = 1'b0;
      mdl = RESET_VALUE;
      lvl_exp = 2'h0;
      `CHK(rd_data, view(mdl, 1'b0))
      for (int i = 0; i < 600; i++) begin
         @(posedge core_clk);
         #1;
         if (rst) begin
            mdl = RESET_VALUE;
            lvl_exp = 2'h0;
            undef_exp = 1'b0;
            unpred_exp = 1'b0;
         end else begin
            mdl = next_mdl(mdl, wr_data, dir_we, ind_we);
            undef_exp = enc_valid && enc_class == ENC_RSV_64;
            unpred_exp = enc_valid && (enc_class == ENC_RSV_INSN ||
                                       enc_class == ENC_RSV_32);
            if (undef_exp)
               lvl_exp = (cur_level == LOWEST_LEVEL) ? DEFAULT_TGT_LEVEL
                                                     : cur_level;
         end
         `CHK(rd_data, view(mdl, 1'b0))
         `CHK(func_bits, view(mdl, 1'b1))
         `CHK(undef_exc, undef_exp)
         `CHK(exc_level, lvl_exp)
         `CHK(unpred_flag, unpred_exp)
         // Second reset in mid-run, held over one edge
         rst = (i == 300);
         if (i < 16) begin
            dir_we = i[0];
            ind_we = i[1];
            wr_data = i[2] ? 32'hFFFF_FFFF : 32'h0000_0000;
            enc_valid = 1'b1;
            enc_class = enc_class_t'(i[1:0]);
            cur_level = i[3:2];
         end else begin
            dir_we = 1'($urandom);
            ind_we = ($urandom % 4) == 0;
            // Half keeps the write policy; half writes freely, as
            // software may for bits reserved only in some contexts
            wr_data = 1'($urandom) ? sw_policy($urandom)
                                   : $urandom;
            enc_valid = 1'($urandom);
            enc_class = enc_class_t'(2'($urandom));
            cur_level = 2'($urandom);
         end
      end
      final_report();
   end
endmodule
